// ==== core/sdc_pkg.sv ====
/*
 * Constants, field layout and carrier types of the synthesizer configuration block.
 * Assumes a single 200 MHz control clock; the analog loop is modelled by timers only.
 */
package sdc_pkg;

	// Configuration word store
	localparam int SDC_NUM_WORDS = 6;
	localparam int SDC_WORD_W = 9;
	localparam int SDC_ADDR_W = 3;
	localparam logic [2:0] SDC_LAST_WORD = 3'h5;

	// Reset values (word 1 is nine bits wide, the others eight)
	localparam logic [8:0] SDC_RST_W0 = 9'h03a;
	localparam logic [8:0] SDC_RST_W1 = 9'h1fa;
	localparam logic [8:0] SDC_RST_W2 = 9'h0c0;
	localparam logic [8:0] SDC_RST_W3 = 9'h01e;
	localparam logic [8:0] SDC_RST_W4 = 9'h001;
	localparam logic [8:0] SDC_RST_W5 = 9'h000;
	localparam logic [8:0] SDC_MASK_W8 = 9'h0ff;
	localparam logic [8:0] SDC_MASK_W9 = 9'h1ff;

	// Setting fields, all held in word 0
	localparam logic [2:0] SDC_SET_WORD = 3'h0;
	localparam int SDC_PRESC_LSB = 0;
	localparam int SDC_TYPE_BIT = 2;
	localparam int SDC_OSC_BIT = 3;
	localparam int SDC_ODIV_LSB = 4;
	localparam logic [2:0] SDC_ODIV_MAX_CODE = 3'h5;

	// Calibration trigger bit
	localparam logic [2:0] SDC_CAL_WORD = 3'h4;
	localparam int SDC_CAL_BIT = 0;

	// Divider tables
	localparam logic [2:0] SDC_PRESC_BASE = 3'h2;
	localparam logic [5:0] SDC_FB_P2 = 6'h20;
	localparam logic [5:0] SDC_FB_P3 = 6'h14;
	localparam logic [5:0] SDC_FB_P4 = 6'h10;
	localparam logic [5:0] SDC_FB_P5 = 6'h0c;
	localparam logic [6:0] SDC_MULT_EVEN = 7'h40;
	localparam logic [6:0] SDC_MULT_ODD = 7'h3c;

	// Timing
	localparam int SDC_CLK_PERIOD_PS = 5000;
	localparam int SDC_CAL_TIME_NS = 1000;
	localparam int SDC_SETTLE_TIME_NS = 500;
	localparam int SDC_CAL_CYC = (SDC_CAL_TIME_NS * 1000 + SDC_CLK_PERIOD_PS - 1) /
		SDC_CLK_PERIOD_PS;
	localparam int SDC_SETTLE_CYC = (SDC_SETTLE_TIME_NS * 1000 + SDC_CLK_PERIOD_PS - 1) /
		SDC_CLK_PERIOD_PS;
	localparam int SDC_CNT_W = 8;

	typedef enum logic [2:0] {
		SDC_ST_BOOT = 3'b000,
		SDC_ST_LOAD = 3'b001,
		SDC_ST_CAL = 3'b010,
		SDC_ST_SETTLE = 3'b011,
		SDC_ST_RUN = 3'b100
	} sdc_state_type;

	typedef struct packed {
		logic osc_high;
		logic [1:0] presc_code;
		logic [2:0] odiv_code;
		logic out_lvds;
	} sdc_set_type;

endpackage : sdc_pkg

// ==== core/sdc_divider_config.sv ====
/*
 * Configuration store, divider selection and recalibration control of the clock synthesizer.
 * Assumes the single-pin link is already decoded into word writes, and that the
 * nonvolatile store answers a read in the cycle its request flop is high.
 */
// How it works
// - Prescaler setting 2 to 5 accepted
// - Feedback divider derived from prescaler table
// - Oscillator multiple 60 odd, 64 even
// - Prescaler times feedback equals oscillator multiple
// - Only output ratios 1 to 32 accepted from the word port; store loads are not checked
// - Output type bit selects LVPECL or LVDS
// - Lock reported only after settling completes
// - Defaults: high band, prescaler 4, divide 8
// - Six words reset to documented defaults
// - Preconfigured store loads words at start-up
// - Enable low then high restarts calibration
`timescale 1ns/1ps
module sdc_divider_config
	import sdc_pkg::*;
#(
	parameter int CAL_CYC = SDC_CAL_CYC,
	parameter int SETTLE_CYC = SDC_SETTLE_CYC
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// Chip enable pin
	input wire logic chip_en_in,
	// Configuration word port
	input wire logic cfg_wr_in,
	input wire logic [SDC_ADDR_W-1:0] cfg_addr_in,
	input wire logic [SDC_WORD_W-1:0] cfg_wdata_in,
	input wire logic [SDC_ADDR_W-1:0] cfg_rd_addr_in,
	output logic [SDC_WORD_W-1:0] cfg_rdata_out,
	output logic cfg_reject_out,
	// Nonvolatile store
	input wire logic nv_valid_in,
	input wire logic [SDC_WORD_W-1:0] nv_data_in,
	output logic nv_rd_out,
	output logic [SDC_ADDR_W-1:0] nv_addr_out,
	// Loop settings and status
	output sdc_set_type active_set_out,
	output logic [2:0] presc_ratio_out,
	output logic [5:0] fb_div_out,
	output logic [6:0] vco_mult_out,
	output logic [5:0] odiv_ratio_out,
	output logic cal_busy_out,
	output logic locked_out
);

	// Counts must fit the phase counter
	if (CAL_CYC < 1 || CAL_CYC > 2 ** SDC_CNT_W) begin : g_cal_chk
		$error("CAL_CYC out of range");
	end
	if (SETTLE_CYC < 1 || SETTLE_CYC > 2 ** SDC_CNT_W) begin : g_settle_chk
		$error("SETTLE_CYC out of range");
	end

	function automatic sdc_set_type sdc_decode(input logic [SDC_WORD_W-1:0] w);
		sdc_set_type s;
		s.presc_code = w[SDC_PRESC_LSB +: 2];
		s.out_lvds = w[SDC_TYPE_BIT];
		s.osc_high = w[SDC_OSC_BIT];
		s.odiv_code = w[SDC_ODIV_LSB +: 3];
		return s;
	endfunction : sdc_decode

	function automatic logic [5:0] sdc_fb(input logic [1:0] p);
		case (p)
			2'h0: return SDC_FB_P2;
			2'h1: return SDC_FB_P3;
			2'h2: return SDC_FB_P4;
			default: return SDC_FB_P5;
		endcase
	endfunction : sdc_fb

	function automatic logic [SDC_WORD_W-1:0] sdc_mask(input logic [SDC_ADDR_W-1:0] a);
		return (a == 3'h1) ? SDC_MASK_W9 : SDC_MASK_W8;
	endfunction : sdc_mask

	sdc_state_type state_r;
	sdc_state_type state_nxt;
	logic [SDC_WORD_W-1:0] words_r [SDC_NUM_WORDS];
	sdc_set_type active_r;
	logic [SDC_CNT_W-1:0] cnt_r;
	logic [SDC_ADDR_W-1:0] load_idx_r;
	logic ce_prev_r;
	logic pending_r;
	logic wr_ok;
	logic wr_bad;
	logic cal_bit_rise;
	logic ce_rise;
	logic trig;
	logic start_cal;
	logic cnt_done;

	// Write decode and trigger detection
	always_comb begin
		wr_bad = cfg_wr_in && ((cfg_addr_in > SDC_LAST_WORD) ||
			(cfg_addr_in == SDC_SET_WORD &&
			cfg_wdata_in[SDC_ODIV_LSB +: 3] > SDC_ODIV_MAX_CODE));
		wr_ok = cfg_wr_in && !wr_bad &&
			(state_r != SDC_ST_BOOT) && (state_r != SDC_ST_LOAD);
		cal_bit_rise = wr_ok && cfg_addr_in == SDC_CAL_WORD &&
			cfg_wdata_in[SDC_CAL_BIT] && !words_r[SDC_CAL_WORD][SDC_CAL_BIT];
		ce_rise = chip_en_in && !ce_prev_r;
		trig = cal_bit_rise || ce_rise;
	end

	// Next state
	always_comb begin
		state_nxt = state_r;
		start_cal = 1'b0;
		cnt_done = 1'b0;
		case (state_r)
			SDC_ST_BOOT: begin
				if (nv_valid_in) begin
					state_nxt = SDC_ST_LOAD;
				end else begin
					state_nxt = SDC_ST_CAL;
					start_cal = 1'b1;
				end
			end
			SDC_ST_LOAD: begin
				if (nv_rd_out && nv_addr_out == SDC_LAST_WORD) begin
					state_nxt = SDC_ST_CAL;
					start_cal = 1'b1;
				end
			end
			SDC_ST_CAL: begin
				cnt_done = (int'(cnt_r) == CAL_CYC - 1);
				if (cnt_done) begin
					state_nxt = SDC_ST_SETTLE;
				end
			end
			SDC_ST_SETTLE: begin
				cnt_done = (int'(cnt_r) == SETTLE_CYC - 1);
				if (cnt_done) begin
					if (pending_r || trig) begin
						state_nxt = SDC_ST_CAL;
						start_cal = 1'b1;
					end else begin
						state_nxt = SDC_ST_RUN;
					end
				end
			end
			SDC_ST_RUN: begin
				if (trig) begin
					state_nxt = SDC_ST_CAL;
					start_cal = 1'b1;
				end
			end
			default: begin
				state_nxt = SDC_ST_BOOT;
			end
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r <= SDC_ST_BOOT;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Phase counter for calibration and settling
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_r <= '0;
		end else if (start_cal || cnt_done || state_r == SDC_ST_RUN) begin
			cnt_r <= '0;
		end else if (state_r == SDC_ST_CAL || state_r == SDC_ST_SETTLE) begin
			cnt_r <= cnt_r + 8'h01;
		end
	end

	// Trigger seen during calibration is kept; the clear at calibration start beats a new trigger
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pending_r <= 1'b0;
		end else if (trig && state_r != SDC_ST_RUN && !start_cal) begin
			pending_r <= 1'b1;
		end else if (start_cal) begin
			pending_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ce_prev_r <= 1'b1;
		end else begin
			ce_prev_r <= chip_en_in;
		end
	end

	// Configuration word store
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			words_r[0] <= SDC_RST_W0;
			words_r[1] <= SDC_RST_W1;
			words_r[2] <= SDC_RST_W2;
			words_r[3] <= SDC_RST_W3;
			words_r[4] <= SDC_RST_W4;
			words_r[5] <= SDC_RST_W5;
		end else if (state_r == SDC_ST_LOAD && nv_rd_out) begin
			words_r[nv_addr_out] <= nv_data_in & sdc_mask(nv_addr_out);
		end else if (wr_ok) begin
			words_r[cfg_addr_in] <= cfg_wdata_in & sdc_mask(cfg_addr_in);
		end
	end

	// Start-up read sequence from the nonvolatile store
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			load_idx_r <= '0;
			nv_rd_out <= 1'b0;
			nv_addr_out <= '0;
		end else if (state_nxt == SDC_ST_LOAD && load_idx_r <= SDC_LAST_WORD) begin
			nv_rd_out <= 1'b1;
			nv_addr_out <= load_idx_r;
			load_idx_r <= load_idx_r + 3'h1;
		end else begin
			nv_rd_out <= 1'b0;
		end
	end

	// Running settings latch, moved only at calibration start
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			active_r <= sdc_decode(SDC_RST_W0);
		end else if (start_cal) begin
			active_r <= sdc_decode(words_r[SDC_SET_WORD]);
		end
	end

	// Derived divider outputs
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			active_set_out <= sdc_decode(SDC_RST_W0);
			presc_ratio_out <= {1'b0, SDC_RST_W0[SDC_PRESC_LSB +: 2]} + SDC_PRESC_BASE;
			fb_div_out <= sdc_fb(SDC_RST_W0[SDC_PRESC_LSB +: 2]);
			vco_mult_out <= SDC_RST_W0[SDC_PRESC_LSB] ? SDC_MULT_ODD : SDC_MULT_EVEN;
			odiv_ratio_out <= 6'h01 << SDC_RST_W0[SDC_ODIV_LSB +: 3];
		end else begin
			active_set_out <= active_r;
			presc_ratio_out <= {1'b0, active_r.presc_code} + SDC_PRESC_BASE;
			fb_div_out <= sdc_fb(active_r.presc_code);
			vco_mult_out <= active_r.presc_code[0] ? SDC_MULT_ODD : SDC_MULT_EVEN;
			odiv_ratio_out <= 6'h01 << active_r.odiv_code;
		end
	end

	// Readback and status
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cfg_rdata_out <= '0;
			cfg_reject_out <= 1'b0;
			cal_busy_out <= 1'b1;
			locked_out <= 1'b0;
		end else begin
			cfg_rdata_out <= (cfg_rd_addr_in <= SDC_LAST_WORD) ? words_r[cfg_rd_addr_in] : '0;
			cfg_reject_out <= wr_bad;
			cal_busy_out <= (state_nxt != SDC_ST_RUN);
			locked_out <= (state_nxt == SDC_ST_RUN) && chip_en_in;
		end
	end

	// Checks
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);

	fb_table_a: assert property (fb_div_out == sdc_fb(active_set_out.presc_code))
		else $error("feedback divider not from prescaler");
	loop_ratio_a: assert property (int'(presc_ratio_out) * int'(fb_div_out) ==
		int'(vco_mult_out)) else $error("detector inputs unequal");
	odd_mult_a: assert property (presc_ratio_out[0] |-> vco_mult_out == SDC_MULT_ODD)
		else $error("odd prescaler multiple wrong");
	odiv_legal_a: assert property (active_r.odiv_code <= SDC_ODIV_MAX_CODE)
		else $error("illegal output divider applied");
	bad_write_a: assert property (cfg_wr_in && cfg_addr_in == SDC_SET_WORD &&
		cfg_wdata_in[SDC_ODIV_LSB +: 3] > SDC_ODIV_MAX_CODE |=> cfg_reject_out &&
		$stable(words_r[0])) else $error("bad divider write not refused");
	apply_trig_a: assert property (!$stable(active_r) |-> $past(start_cal))
		else $error("settings moved without recalibration");
	cal_hold_a: assert property ((state_r == SDC_ST_CAL || state_r == SDC_ST_SETTLE) &&
		!start_cal |=> $stable(active_r)) else $error("settings moved during calibration");
	ce_restart_a: assert property (state_r == SDC_ST_RUN && chip_en_in && !ce_prev_r
		|=> state_r == SDC_ST_CAL) else $error("enable toggle missed");
	cal_len_a: assert property ($fell(state_r == SDC_ST_CAL) |->
		int'($past(cnt_r)) == CAL_CYC - 1) else $error("calibration length wrong");
	lock_run_a: assert property (locked_out |-> state_r == SDC_ST_RUN && !cal_busy_out)
		else $error("lock outside run");
	nv_load_a: assert property (state_r == SDC_ST_LOAD && nv_rd_out |=>
		words_r[$past(nv_addr_out)] == ($past(nv_data_in) & sdc_mask($past(nv_addr_out))))
		else $error("stored word not loaded");
	boot_dflt_a: assert property (state_r == SDC_ST_BOOT |-> words_r[0] == SDC_RST_W0 &&
		active_r == sdc_decode(SDC_RST_W0)) else $error("defaults lost");

	load_c: cover property (state_r == SDC_ST_LOAD ##1 state_r == SDC_ST_CAL);
	bit_trig_c: cover property (state_r == SDC_ST_RUN && cal_bit_rise);
	ce_trig_c: cover property (state_r == SDC_ST_RUN && ce_rise);
	pend_c: cover property (pending_r && start_cal);
	reject_c: cover property (cfg_reject_out);

endmodule : sdc_divider_config

// ==== tb/sdc_host_model.sv ====
/* Host and store model: word writes, chip enable toggles, a preloaded store.
 * Assumes the bench clock; store reads are requested by a registered strobe. */
`timescale 1ns/1ps
module sdc_host_model
	import sdc_pkg::*;
(
	// Clock
	input wire logic ref_clk_in,
	// Host side
	output logic chip_en_out,
	output logic cfg_wr_out,
	output logic [SDC_ADDR_W-1:0] cfg_addr_out,
	output logic [SDC_WORD_W-1:0] cfg_wdata_out,
	// Store side
	input wire logic nv_rd_in,
	input wire logic [SDC_ADDR_W-1:0] nv_addr_in,
	output logic [SDC_WORD_W-1:0] nv_data_out
);
	logic [SDC_WORD_W-1:0] store_r [SDC_NUM_WORDS];
	initial begin
		chip_en_out = 1'b1;
		cfg_wr_out = 1'b0;
		cfg_addr_out = 3'h0;
		cfg_wdata_out = 9'h000;
		// Prescaler 3, divide 32, high band, reference 31 to 38.5 MHz
		store_r = '{9'h15d, 9'h1a5, 9'h022, 9'h033, 9'h100, 9'h044};
	end
	// Unread store lines show the inverse
	assign nv_data_out = nv_rd_in ? store_r[nv_addr_in] : ~store_r[nv_addr_in];
	task automatic write_word(input logic [2:0] a, input logic [8:0] d);
		@(posedge ref_clk_in);
		cfg_wr_out <= 1'b1;
		cfg_addr_out <= a;
		cfg_wdata_out <= d;
		@(posedge ref_clk_in);
		cfg_wr_out <= 1'b0;
		cfg_wdata_out <= ~d;
	endtask : write_word
	// Cal bit cleared then set
	task automatic recal();
		write_word(SDC_CAL_WORD, 9'h000);
		write_word(SDC_CAL_WORD, 9'h001);
	endtask : recal
	task automatic toggle_ce();
		@(posedge ref_clk_in);
		chip_en_out <= 1'b0;
		@(posedge ref_clk_in);
		chip_en_out <= 1'b1;
		@(posedge ref_clk_in);
	endtask : toggle_ce
endmodule : sdc_host_model

// ==== tb/synth_divider_config_bench.sv ====
/* Self-checking bench of the divider configuration block.
 * Assumes short calibration counts and the host model as word source. */
`timescale 1ns/1ps
module synth_divider_config_bench
	import sdc_pkg::*;
;
	localparam int CAL = 4;
	localparam int SETTLE = 3;
	localparam logic [8:0] RST_W [6] = '{9'h03a, 9'h1fa, 9'h0c0, 9'h01e, 9'h001, 9'h000};
	localparam logic [8:0] NV_W [6] = '{9'h05d, 9'h1a5, 9'h022, 9'h033, 9'h000, 9'h044};
	logic ref_clk_in, rst_n_in, chip_en, cfg_wr, nv_valid, nv_rd, reject, busy, locked;
	logic [2:0] cfg_addr, rd_addr, nv_addr, presc;
	logic [8:0] wdata, rdata, nv_data, prev;
	logic [5:0] fb, odiv;
	logic [6:0] mult;
	sdc_set_type act;
	int mismatches, n_tests, n_rej;
	sdc_divider_config #(.CAL_CYC(CAL), .SETTLE_CYC(SETTLE)) i_dut (
		.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .chip_en_in(chip_en),
		.cfg_wr_in(cfg_wr), .cfg_addr_in(cfg_addr), .cfg_wdata_in(wdata),
		.cfg_rd_addr_in(rd_addr), .cfg_rdata_out(rdata), .cfg_reject_out(reject),
		.nv_valid_in(nv_valid), .nv_data_in(nv_data), .nv_rd_out(nv_rd),
		.nv_addr_out(nv_addr), .active_set_out(act), .presc_ratio_out(presc),
		.fb_div_out(fb), .vco_mult_out(mult), .odiv_ratio_out(odiv),
		.cal_busy_out(busy), .locked_out(locked));
	sdc_host_model i_host (
		.ref_clk_in(ref_clk_in), .chip_en_out(chip_en), .cfg_wr_out(cfg_wr),
		.cfg_addr_out(cfg_addr), .cfg_wdata_out(wdata), .nv_rd_in(nv_rd),
		.nv_addr_in(nv_addr), .nv_data_out(nv_data));
	initial begin
		ref_clk_in = 1'b0;
		forever #2.5 ref_clk_in = ~ref_clk_in;
	end
	always @(negedge ref_clk_in) begin
		if (reject === 1'b1) n_rej++;
	end
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic close_out();
		if (mismatches == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : close_out
	task automatic rd_check(input logic [2:0] a, input logic [8:0] exp);
		@(posedge ref_clk_in);
		rd_addr <= a;
		@(posedge ref_clk_in);
		#1 check(rdata, exp);
	endtask : rd_check
	task automatic wait_lock(input int exp);
		int n;
		n = 0;
		#1;
		repeat (100) begin
			if (locked === 1'b1) break;
			if (busy === 1'b1) n++;
			@(posedge ref_clk_in);
			#1;
		end
		if (exp > 0) check(9'(n), 9'(exp));
		check({8'h00, locked}, 9'h001);
	endtask : wait_lock
	task automatic check_set(input logic [8:0] w);
		sdc_set_type e;
		logic [5:0] f;
		e = '{w[3], w[1:0], w[6:4], w[2]};
		f = (w[1:0] == 2'h0) ? 6'h20 : (w[1:0] == 2'h1) ? 6'h14 :
			(w[1:0] == 2'h2) ? 6'h10 : 6'h0c;
		check({2'h0, act}, {2'h0, e});
		check({6'h0, presc}, 9'(w[1:0]) + 9'h002);
		check({3'h0, fb}, {3'h0, f});
		check({2'h0, mult}, w[0] ? 9'h03c : 9'h040);
		check(9'(presc) * 9'(fb), {2'h0, mult});
		check({3'h0, odiv}, 9'h001 << w[6:4]);
	endtask : check_set
	task automatic t_reset();
		wait_lock(0);
		foreach (RST_W[i]) rd_check(3'(i), RST_W[i]);
		rd_check(3'h6, 9'h000);
		check_set(9'h03a);
	endtask : t_reset
	task automatic t_presc();
		logic [8:0] w;
		prev = 9'h03a;
		for (logic [2:0] k = 3'h0; k < 3'h6; k++) begin
			w = {2'h0, k, k[1], k[0], k[1:0]};
			i_host.write_word(3'h0, w);
			check_set(prev);
			i_host.recal();
			wait_lock(CAL + SETTLE);
			check_set(w);
			rd_check(3'h0, w);
			prev = w;
		end
	endtask : t_presc
	task automatic t_reject();
		int n0;
		n0 = n_rej;
		i_host.write_word(3'h0, 9'h060);
		i_host.write_word(3'h6, 9'h0aa);
		i_host.write_word(3'h2, 9'h1c3);
		repeat (2) @(posedge ref_clk_in);
		check(9'(n_rej - n0), 9'h002);
		rd_check(3'h0, prev);
		rd_check(3'h2, 9'h0c3);
	endtask : t_reject
	task automatic t_freeze();
		i_host.write_word(3'h0, 9'h021);
		i_host.recal();
		i_host.write_word(3'h0, 9'h052);
		check({8'h00, busy}, 9'h001);
		check_set(9'h021);
		wait_lock(0);
		check_set(9'h021);
		i_host.toggle_ce();
		wait_lock(CAL + SETTLE);
		check_set(9'h052);
	endtask : t_freeze
	task automatic t_store();
		@(posedge ref_clk_in);
		rst_n_in <= 1'b0;
		nv_valid <= 1'b1;
		repeat (3) @(posedge ref_clk_in);
		rst_n_in <= 1'b1;
		repeat (10) begin
			@(posedge ref_clk_in);
			#1;
			if (nv_rd === 1'b1) break;
		end
		for (int k = 0; k < 6; k++) begin
			check({5'h00, nv_rd, nv_addr}, {6'h01, 3'(k)});
			@(posedge ref_clk_in);
			#1;
		end
		wait_lock(0);
		foreach (NV_W[i]) rd_check(3'(i), NV_W[i]);
		check_set(9'h05d);
	endtask : t_store
	initial begin
		rst_n_in = 1'b0;
		nv_valid = 1'b0;
		rd_addr = 3'h0;
		repeat (20) @(posedge ref_clk_in);
		rst_n_in <= 1'b1;
		t_reset();
		t_presc();
		t_reject();
		t_freeze();
		t_store();
		close_out();
	end
	initial begin
		#20000;
		mismatches++;
		close_out();
	end
endmodule : synth_divider_config_bench
